// ---- rtl/ecl_loader.v ----
`timescale 1ns/1ps
`include "ecl_defs.vh"

// Functional notes
// - Word 06h bit 0 gives extra VC count at 144h bit 0, all ports.
// - Word 06h bits 3:1 give L0s exit latency at CCh bits 14:12.
// - Word 06h bits 6:4 give L1 exit latency at CCh bits 17:15.
// - Word 06h bits 7,10,12:11 give store-forward modes and cut-through threshold at 74h.
// - Word 06h bit 8 disables ordering across egress ports, 74h bit 5.
// - Word 06h bit 9 disables ordering across completion tags, 74h bit 6.
// - Word 06h bits 13,14 select arbiter and credit update modes, 74h bits 3,4.
// - Word 06h bit 15 sets INTA request at 3Ch bit 8 on ports 1 and 2.
// - Word 0Ch bits 1:0 give max payload support at C4h bits 1:0.
// - Word 0Ch bits 3:2 give ASPM support at CCh bits 11:10.
// - Word 0Ch bit 4 advertises role-based error reporting at C4h bit 15.
// - Word 0Ch bit 5 removes MSI capability, 70h bit 14.
// - Word 0Ch bit 6 disables compliance pattern parity, 74h bit 15.
// - Word 0Ch bit 7 removes power management capability, 70h bit 13.
// - Word 0Ch bit 8 lets posted pass non-posted, 8Ch bit 5.
// - Word 0Ch bit 9 advertises bandwidth notification at CCh bit 21, downstream ports.
// - Word 0Eh bits 14:0 load transmit margin levels at 94h bits 14:0.
module ecl_loader #(
  parameter [15:0] SIG_VALUE = 16'hA55A,  // Arbitrary value
  parameter [15:0] DEF_VENDOR = 16'h1001, // Arbitrary value
  parameter [15:0] DEF_DEVICE = 16'h2002  // Arbitrary value
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // EEPROM word read
  output wire ee_rd_req,
  output wire [7:0] ee_word_addr,
  input wire ee_rd_ack,
  input wire [15:0] ee_rd_data,
  // Loaded configuration, shared by all ports
  output reg [15:0] vendor_id,
  output reg [15:0] device_id,
  output reg [15:0] subsys_vendor_id,
  output reg [15:0] subsys_id,
  output reg [15:0] cfg_word06,
  output reg [15:0] cfg_word0c,
  output reg [15:0] cfg_word0e,
  output reg load_done
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ISSUE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  reg [1:0] state;
  reg [7:0] addr;
  reg sig_ok;
  reg sig_bad;
  reg [15:0] sig_word;
  reg [3:0] word_cnt;
  reg wr_pend;
  reg [12:0] wr_addr;
  reg [31:0] rd_mux;
  wire rd_done;
  wire [15:0] rd_data;
  wire acc;
  wire reload_req;
  wire [1:0] rd_port;

  // ----------------------------------------
  // Per-port configuration dword view
  // ----------------------------------------
  function [31:0] cfg_dword;
    input [1:0] port;
    input [8:0] off;
    reg [31:0] d;
    begin
      d = 32'h0000_0000;
      case (off)
        `ECL_CFG_ID: begin
          d = {device_id, vendor_id};
        end
        `ECL_CFG_INT: begin
          d[`ECL_D_INTA] = (port != `ECL_PORT_UP) & cfg_word06[`ECL_S_INTA];
        end
        `ECL_CFG_CAPDIS: begin
          d[`ECL_D_MSIDIS] = cfg_word0c[`ECL_S_MSIDIS];
          d[`ECL_D_PMDIS] = cfg_word0c[`ECL_S_PMDIS];
        end
        `ECL_CFG_SWMODE: begin
          d[`ECL_D_NPSF] = cfg_word06[`ECL_S_NPSF];
          d[`ECL_D_SF] = cfg_word06[`ECL_S_SF];
          d[`ECL_D_CT +: `ECL_W_CT] = cfg_word06[`ECL_S_CT +: `ECL_W_CT];
          d[`ECL_D_NOEG] = cfg_word06[`ECL_S_NOEG];
          d[`ECL_D_NOTAG] = cfg_word06[`ECL_S_NOTAG];
          d[`ECL_D_ARB] = cfg_word06[`ECL_S_ARB];
          d[`ECL_D_CRED] = cfg_word06[`ECL_S_CRED];
          d[`ECL_D_PARDIS] = cfg_word0c[`ECL_S_PARDIS];
        end
        `ECL_CFG_ORDER: begin
          d[`ECL_D_PPNP] = cfg_word0c[`ECL_S_PPNP];
        end
        `ECL_CFG_TXMGN: begin
          d[`ECL_D_MGN +: `ECL_W_MGN] = cfg_word0e[`ECL_S_MGN +: `ECL_W_MGN];
        end
        `ECL_CFG_SUBSYS: begin
          d = {subsys_id, subsys_vendor_id};
        end
        `ECL_CFG_DEVCAP: begin
          d[`ECL_D_MPS +: `ECL_W_MPS] = cfg_word0c[`ECL_S_MPS +: `ECL_W_MPS];
          d[`ECL_D_RBER] = cfg_word0c[`ECL_S_RBER];
        end
        `ECL_CFG_LNKCAP: begin
          d[`ECL_D_L0S +: `ECL_W_LAT] = cfg_word06[`ECL_S_L0S +: `ECL_W_LAT];
          d[`ECL_D_L1 +: `ECL_W_LAT] = cfg_word06[`ECL_S_L1 +: `ECL_W_LAT];
          d[`ECL_D_ASPM +: `ECL_W_ASPM] = cfg_word0c[`ECL_S_ASPM +: `ECL_W_ASPM];
          d[`ECL_D_LBN] = (port != `ECL_PORT_UP) & cfg_word0c[`ECL_S_LBN];
        end
        `ECL_CFG_VCCAP: begin
          d[`ECL_D_VC] = cfg_word06[`ECL_S_VC];
        end
        default: begin
          d = 32'h0000_0000;
        end
      endcase
      cfg_dword = d;
    end
  endfunction

  // ----------------------------------------
  // EEPROM reader
  // ----------------------------------------
  ecl_ee_reader u_reader (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(state == ST_ISSUE),
    .addr(addr),
    .done(rd_done),
    .data(rd_data),
    .ee_rd_req(ee_rd_req),
    .ee_word_addr(ee_word_addr),
    .ee_rd_ack(ee_rd_ack),
    .ee_rd_data(ee_rd_data)
  );

  // ----------------------------------------
  // Load sequencer
  // ----------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_ISSUE;
      addr <= `ECL_EE_SIG;
      sig_ok <= 1'b0;
      sig_bad <= 1'b0;
      sig_word <= 16'h0000;
      word_cnt <= 4'h0;
      load_done <= 1'b0;
      vendor_id <= DEF_VENDOR;
      device_id <= DEF_DEVICE;
      subsys_vendor_id <= `ECL_DEF_SUB;
      subsys_id <= `ECL_DEF_SUB;
      cfg_word06 <= `ECL_DEF_W06;
      cfg_word0c <= `ECL_DEF_W0C;
      cfg_word0e <= `ECL_DEF_W0E;
    end else begin
      case (state)
        ST_IDLE: begin
          if (reload_req) begin
            vendor_id <= DEF_VENDOR;
            device_id <= DEF_DEVICE;
            subsys_vendor_id <= `ECL_DEF_SUB;
            subsys_id <= `ECL_DEF_SUB;
            cfg_word06 <= `ECL_DEF_W06;
            cfg_word0c <= `ECL_DEF_W0C;
            cfg_word0e <= `ECL_DEF_W0E;
            sig_ok <= 1'b0;
            sig_bad <= 1'b0;
            word_cnt <= 4'h0;
            load_done <= 1'b0;
            addr <= `ECL_EE_SIG;
            state <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (rd_done) begin
            word_cnt <= word_cnt + 4'h1;
            if (addr == `ECL_EE_SIG) begin
              sig_word <= rd_data;
              if (rd_data == SIG_VALUE) begin
                sig_ok <= 1'b1;
                addr <= addr + `ECL_EE_STEP;
                state <= ST_ISSUE;
              end else begin
                sig_bad <= 1'b1;
                load_done <= 1'b1;
                state <= ST_IDLE;
              end
            end else begin
              case (addr)
                `ECL_EE_VID: vendor_id <= rd_data;
                `ECL_EE_DID: device_id <= rd_data;
                `ECL_EE_SVID: subsys_vendor_id <= rd_data;
                `ECL_EE_SID: subsys_id <= rd_data;
                `ECL_EE_W06: cfg_word06 <= rd_data;
                `ECL_EE_W0C: cfg_word0c <= rd_data;
                `ECL_EE_W0E: cfg_word0e <= rd_data;
                default: begin
                end
              endcase
              if (addr == `ECL_EE_LAST) begin
                load_done <= 1'b1;
                state <= ST_IDLE;
              end else begin
                addr <= addr + `ECL_EE_STEP;
                state <= ST_ISSUE;
              end
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  assign acc = hsel & htrans[1] & hready;
  assign rd_port = haddr[`ECL_PORT_HI:`ECL_PORT_LO];
  // Reload only honoured while idle
  assign reload_req = wr_pend & (wr_addr == `ECL_REG_CTRL) & hwdata[`ECL_CTRL_RELOAD];

  always @* begin
    rd_mux = 32'h0000_0000;
    if (haddr[`ECL_WIN_BIT]) begin
      if (rd_port != `ECL_NPORT) begin
        rd_mux = cfg_dword(rd_port, {haddr[`ECL_OFF_HI:`ECL_OFF_LO], 2'b00});
      end
    end else begin
      case (haddr[12:0])
        `ECL_REG_STAT: begin
          rd_mux[`ECL_ST_BUSY] = (state != ST_IDLE);
          rd_mux[`ECL_ST_DONE] = load_done;
          rd_mux[`ECL_ST_SIGOK] = sig_ok;
          rd_mux[`ECL_ST_SIGBAD] = sig_bad;
        end
        `ECL_REG_SIG: rd_mux = {16'h0000, sig_word};
        `ECL_REG_CNT: rd_mux = {28'h000_0000, word_cnt};
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      wr_pend <= 1'b0;
      wr_addr <= 13'h0000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= acc & hwrite;
      if (acc) begin
        wr_addr <= haddr[12:0];
      end
      if (acc & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

endmodule

// ---- rtl/ecl_defs.vh ----
`ifndef ECL_DEFS_VH
`define ECL_DEFS_VH

// ----------------------------------------
// EEPROM word addresses
// ----------------------------------------
`define ECL_EE_SIG 8'h00
`define ECL_EE_VID 8'h02
`define ECL_EE_DID 8'h04
`define ECL_EE_W06 8'h06
`define ECL_EE_SVID 8'h08
`define ECL_EE_SID 8'h0A
`define ECL_EE_W0C 8'h0C
`define ECL_EE_W0E 8'h0E
`define ECL_EE_LAST 8'h0E
`define ECL_EE_STEP 8'h02

// ----------------------------------------
// Hardware defaults
// ----------------------------------------
`define ECL_DEF_W06 16'h0806
`define ECL_DEF_W0C 16'h001D
`define ECL_DEF_W0E 16'h916B
`define ECL_DEF_SUB 16'h0000

// ----------------------------------------
// Configuration dword offsets
// ----------------------------------------
`define ECL_CFG_ID 9'h000
`define ECL_CFG_INT 9'h03C
`define ECL_CFG_CAPDIS 9'h070
`define ECL_CFG_SWMODE 9'h074
`define ECL_CFG_ORDER 9'h08C
`define ECL_CFG_TXMGN 9'h094
`define ECL_CFG_SUBSYS 9'h0B4
`define ECL_CFG_DEVCAP 9'h0C4
`define ECL_CFG_LNKCAP 9'h0CC
`define ECL_CFG_VCCAP 9'h144
`define ECL_PORT_UP 2'h0
`define ECL_NPORT 2'h3

// ----------------------------------------
// Field positions: S_ in EEPROM word, D_ in dword
// ----------------------------------------
`define ECL_S_VC 0
`define ECL_D_VC 0
`define ECL_S_L0S 1
`define ECL_D_L0S 12
`define ECL_S_L1 4
`define ECL_D_L1 15
`define ECL_W_LAT 3
`define ECL_S_NPSF 7
`define ECL_D_NPSF 7
`define ECL_S_NOEG 8
`define ECL_D_NOEG 5
`define ECL_S_NOTAG 9
`define ECL_D_NOTAG 6
`define ECL_S_SF 10
`define ECL_D_SF 0
`define ECL_S_CT 11
`define ECL_D_CT 1
`define ECL_W_CT 2
`define ECL_S_ARB 13
`define ECL_D_ARB 3
`define ECL_S_CRED 14
`define ECL_D_CRED 4
`define ECL_S_INTA 15
`define ECL_D_INTA 8
`define ECL_S_MPS 0
`define ECL_D_MPS 0
`define ECL_W_MPS 2
`define ECL_S_ASPM 2
`define ECL_D_ASPM 10
`define ECL_W_ASPM 2
`define ECL_S_RBER 4
`define ECL_D_RBER 15
`define ECL_S_MSIDIS 5
`define ECL_D_MSIDIS 14
`define ECL_S_PARDIS 6
`define ECL_D_PARDIS 15
`define ECL_S_PMDIS 7
`define ECL_D_PMDIS 13
`define ECL_S_PPNP 8
`define ECL_D_PPNP 5
`define ECL_S_LBN 9
`define ECL_D_LBN 21
`define ECL_S_MGN 0
`define ECL_D_MGN 0
`define ECL_W_MGN 15

// ----------------------------------------
// AHB register map
// ----------------------------------------
`define ECL_REG_CTRL 13'h0000
`define ECL_REG_STAT 13'h0004
`define ECL_REG_SIG 13'h0008
`define ECL_REG_CNT 13'h000C
`define ECL_WIN_BIT 12
`define ECL_PORT_HI 10
`define ECL_PORT_LO 9
`define ECL_OFF_HI 8
`define ECL_OFF_LO 2
`define ECL_CTRL_RELOAD 0
`define ECL_ST_BUSY 0
`define ECL_ST_DONE 1
`define ECL_ST_SIGOK 2
`define ECL_ST_SIGBAD 3

`endif

// ---- rtl/ecl_ee_reader.v ----
`timescale 1ns/1ps

module ecl_ee_reader (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Request from the sequencer
  input wire start,
  input wire [7:0] addr,
  output reg done,
  output reg [15:0] data,
  // EEPROM word read
  output reg ee_rd_req,
  output reg [7:0] ee_word_addr,
  input wire ee_rd_ack,
  input wire [15:0] ee_rd_data
);

  // Request held until the EEPROM acknowledges with its data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ee_rd_req <= 1'b0;
      ee_word_addr <= 8'h00;
      done <= 1'b0;
      data <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (ee_rd_req) begin
        if (ee_rd_ack) begin
          ee_rd_req <= 1'b0;
          done <= 1'b1;
          data <= ee_rd_data;
        end
      end else if (start) begin
        ee_rd_req <= 1'b1;
        ee_word_addr <= addr;
      end
    end
  end

endmodule

// ---- tb/ecl_loader_checker.sv ----
`timescale 1ns/1ps

module ecl_loader_checker #(
  parameter [15:0] SIG_VALUE = 16'hA55A,
  parameter [15:0] DEF_VENDOR = 16'h1001
) (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus answer
  input wire hreadyout,
  input wire hresp,
  // EEPROM link
  input wire ee_rd_req,
  input wire [7:0] ee_word_addr,
  input wire ee_rd_ack,
  input wire [15:0] ee_rd_data,
  // Loaded words
  input wire [15:0] vendor_id,
  input wire [15:0] subsys_id,
  input wire [15:0] cfg_word06,
  input wire [15:0] cfg_word0c,
  input wire [15:0] cfg_word0e,
  input wire load_done
);
  // ----------------------------------------
  // Last word taken from the EEPROM
  // ----------------------------------------
  wire took = ee_rd_req && ee_rd_ack;
  reg [15:0] cap;
  reg [7:0] last_a;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap <= 16'h0000;
      last_a <= 8'h00;
    end else if (took) begin
      cap <= ee_rd_data;
      last_a <= ee_word_addr;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  AST_REQ_HOLD: assert property (ee_rd_req && !ee_rd_ack |=> ee_rd_req && $stable(ee_word_addr))
    else $error("eeprom request dropped or moved before ack");
  AST_REQ_DROP: assert property (took |=> !ee_rd_req ##1 !ee_rd_req)
    else $error("eeprom request not released after ack");
  AST_ADDR_NEXT: assert property (
    took && ee_word_addr < 8'h0E && (ee_word_addr != 8'h00 || ee_rd_data == SIG_VALUE)
    |-> ##[2:3] ee_rd_req && ee_word_addr == last_a + 8'h02) else $error("next eeprom word not requested");
  AST_BAD_SIG: assert property (
    took && ee_word_addr == 8'h00 && ee_rd_data != SIG_VALUE |-> ##[1:3] load_done ##1
    (vendor_id == DEF_VENDOR && cfg_word06 == 16'h0806 && subsys_id == 16'h0000 && !ee_rd_req))
    else $error("bad signature did not keep defaults");
  AST_ID_LOAD: assert property (took && ee_word_addr == 8'h02 |-> ##[1:2] vendor_id == cap)
    else $error("vendor word not loaded");
  AST_W06: assert property (took && ee_word_addr == 8'h06 |-> ##[1:2] cfg_word06 == cap)
    else $error("word 06h not loaded");
  AST_W0C: assert property (took && ee_word_addr == 8'h0C |-> ##[1:2] cfg_word0c == cap)
    else $error("word 0Ch not loaded");
  AST_W0E: assert property (took && ee_word_addr == 8'h0E |-> ##[1:2] cfg_word0e == cap)
    else $error("word 0Eh not loaded");
  AST_DONE: assert property (took && ee_word_addr == 8'h0E |-> ##[1:3] load_done && !ee_rd_req)
    else $error("load not finished after last word");
  COV_FULL: cover property (took && ee_word_addr == 8'h0E);
  COV_BAD: cover property (took && ee_word_addr == 8'h00 && ee_rd_data != SIG_VALUE);
  COV_SLOW: cover property (ee_rd_req && !ee_rd_ack [*3]);
endmodule

bind ecl_loader ecl_loader_checker #(.SIG_VALUE(SIG_VALUE), .DEF_VENDOR(DEF_VENDOR)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .ee_rd_req(ee_rd_req), .ee_word_addr(ee_word_addr),
  .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data), .vendor_id(vendor_id), .subsys_id(subsys_id),
  .cfg_word06(cfg_word06), .cfg_word0c(cfg_word0c), .cfg_word0e(cfg_word0e), .load_done(load_done));

// ---- tb/ecl_ee_model.sv ----
`timescale 1ns/1ps

module ecl_ee_model (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Word read
  input wire ee_rd_req,
  input wire [7:0] ee_word_addr,
  output reg ee_rd_ack,
  output reg [15:0] ee_rd_data
);
  reg [15:0] mem [0:7];
  integer lat;
  integer cnt;
  // Data outside the ack cycle toggles every cycle, back to the last word every other cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ee_rd_ack <= 1'b0;
      ee_rd_data <= 16'h0000;
      cnt <= 0;
    end else if (ee_rd_req && !ee_rd_ack && cnt >= lat) begin
      ee_rd_ack <= 1'b1;
      ee_rd_data <= mem[ee_word_addr[3:1]];
      cnt <= 0;
    end else begin
      ee_rd_ack <= 1'b0;
      ee_rd_data <= ~ee_rd_data;
      cnt <= ee_rd_req ? cnt + 1 : 0;
    end
  end
endmodule

// ---- tb/ecl_testbench.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin errors = errors + 1; \
  $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end

module testbench;
  localparam [15:0] SIG = 16'h5AC3; // Arbitrary value
  localparam [15:0] DV = 16'h3C3C; // Arbitrary value
  localparam [15:0] DD = 16'h4D4D; // Arbitrary value
  localparam [89:0] OFFS = {9'h000, 9'h03C, 9'h070, 9'h074, 9'h08C, 9'h094, 9'h0B4, 9'h0C4, 9'h0CC, 9'h144};
  reg hclk, hresetn, hsel, hwrite;
  reg [31:0] haddr, hwdata, rd;
  reg [1:0] htrans;
  reg [2:0] hsize;
  wire hreadyout, hresp, ee_rd_req, ee_rd_ack, load_done;
  wire [31:0] hrdata;
  wire [7:0] ee_word_addr;
  wire [15:0] ee_rd_data, vendor_id, device_id, subsys_vendor_id, subsys_id, cfg_word06, cfg_word0c, cfg_word0e;
  integer errors, n_tests, p, k;

  ecl_loader #(.SIG_VALUE(SIG), .DEF_VENDOR(DV), .DEF_DEVICE(DD)) dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ee_rd_req(ee_rd_req),
    .ee_word_addr(ee_word_addr), .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data), .vendor_id(vendor_id),
    .device_id(device_id), .subsys_vendor_id(subsys_vendor_id), .subsys_id(subsys_id),
    .cfg_word06(cfg_word06), .cfg_word0c(cfg_word0c), .cfg_word0e(cfg_word0e), .load_done(load_done));
  ecl_ee_model ee (.hclk(hclk), .hresetn(hresetn), .ee_rd_req(ee_rd_req), .ee_word_addr(ee_word_addr),
    .ee_rd_ack(ee_rd_ack), .ee_rd_data(ee_rd_data));

  // ----------------------------------------
  // Bus cycles and expectations
  // ----------------------------------------
  task ahb(input w, input [31:0] a, input [31:0] wd, output [31:0] r);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
    end
  endtask

  function [63:0] expd(input [1:0] q, input [8:0] o, input [15:0] a, c, e, vi, di, si, su);
    begin
      case (o)
        9'h000: expd = {32'hFFFF_FFFF, di, vi};
        9'h0B4: expd = {32'hFFFF_FFFF, su, si};
        9'h144: expd = {32'h0000_0001, 31'h0, a[0]};
        9'h0CC: expd = {32'h0023_FC00, 10'h0, (q != 2'h0) & c[9], 3'h0, a[6:4], a[3:1], c[3:2], 10'h0};
        9'h074: expd = {32'h0000_80FF, 16'h0, c[6], 7'h0, a[7], a[9], a[8], a[14], a[13], a[12:11], a[10]};
        9'h03C: expd = {32'h0000_0100, 23'h0, (q != 2'h0) & a[15], 8'h0};
        9'h0C4: expd = {32'h0000_8003, 16'h0, c[4], 13'h0, c[1:0]};
        9'h070: expd = {32'h0000_6000, 17'h0, c[5], c[7], 13'h0};
        9'h08C: expd = {32'h0000_0020, 26'h0, c[8], 5'h0};
        default: expd = {32'h0000_7FFF, 17'h0, e[14:0]};
      endcase
    end
  endfunction

  task check_all(input [15:0] a, c, e, vi, di, si, su, input [3:0] st);
    reg [63:0] x;
    begin
      `CHK({vendor_id, device_id, subsys_vendor_id, subsys_id}, {vi, di, si, su})
      `CHK({cfg_word06, cfg_word0c, cfg_word0e}, {a, c, e})
      ahb(1'b0, 32'h0000_0004, 32'h0, rd);
      `CHK(rd[3:0], st)
      for (p = 0; p < 3; p = p + 1) begin
        for (k = 0; k < 10; k = k + 1) begin
          ahb(1'b0, 32'h0000_1000 + p * 32'h200 + OFFS[k * 9 +: 9], 32'h0, rd);
          x = expd(p[1:0], OFFS[k * 9 +: 9], a, c, e, vi, di, si, su);
          `CHK(rd & x[63:32], x[31:0])
        end
      end
    end
  endtask

  task reload(input [15:0] s, a, c, e, vi, di, si, su);
    begin
      ee.mem[0] = s;
      ee.mem[1] = vi;
      ee.mem[2] = di;
      ee.mem[3] = a;
      ee.mem[4] = si;
      ee.mem[5] = su;
      ee.mem[6] = c;
      ee.mem[7] = e;
      ahb(1'b1, 32'h0000_0000, 32'h0000_0001, rd);
      @(posedge hclk);
      while (load_done !== 1'b1) @(posedge hclk);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_defaults;
    begin
      while (load_done !== 1'b1) @(posedge hclk);
      check_all(16'h0806, 16'h001D, 16'h916B, DV, DD, 16'h0, 16'h0, 4'hA);
    end
  endtask

  task t_load_fast;
    begin
      ee.lat = 0;
      reload(SIG, 16'hAAAA, 16'h02AA, 16'h2AAA, 16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0);
      check_all(16'hAAAA, 16'h02AA, 16'h2AAA, 16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0, 4'h6);
      ahb(1'b0, 32'h0000_0008, 32'h0, rd);
      `CHK(rd, {16'h0000, SIG})
      ahb(1'b0, 32'h0000_000C, 32'h0, rd);
      `CHK(rd, 32'h0000_0008)
    end
  endtask

  task t_load_slow;
    begin
      ee.lat = 5;
      reload(SIG, 16'h5555, 16'h0155, 16'h5555, 16'hEDCB, 16'hA987, 16'h6543, 16'h210F);
      check_all(16'h5555, 16'h0155, 16'h5555, 16'hEDCB, 16'hA987, 16'h6543, 16'h210F, 4'h6);
    end
  endtask

  task t_bad_after_good;
    begin
      reload(~SIG, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF);
      check_all(16'h0806, 16'h001D, 16'h916B, DV, DD, 16'h0, 16'h0, 4'hA);
      ahb(1'b0, 32'h0000_0008, 32'h0, rd);
      `CHK(rd, {16'h0000, ~SIG})
      ahb(1'b0, 32'h0000_000C, 32'h0, rd);
      `CHK(rd, 32'h0000_0001)
    end
  endtask

  // Reset in the middle of a load brings back defaults, then the load restarts
  task t_reset_mid;
    begin
      ahb(1'b1, 32'h0000_0000, 32'h0000_0001, rd);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      `CHK({vendor_id, cfg_word06, load_done, ee_rd_req}, {DV, 16'h0806, 2'b00})
      hresetn <= 1'b1;
      while (load_done !== 1'b1) @(posedge hclk);
      check_all(16'h5555, 16'h0155, 16'h5555, 16'hEDCB, 16'hA987, 16'h6543, 16'h210F, 4'h6);
    end
  endtask

  task t_unmapped;
    begin
      ahb(1'b0, 32'h0000_1600, 32'h0, rd);
      `CHK(rd, 32'h0000_0000)
      ahb(1'b0, 32'h0000_0010, 32'h0, rd);
      `CHK(rd, 32'h0000_0000)
      ahb(1'b1, 32'h0000_0000, 32'h0, rd);
      ahb(1'b0, 32'h0000_0004, 32'h0, rd);
      `CHK(rd[3:0], 4'hA)
    end
  endtask

  task tally_and_finish;
    begin
      if (errors == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    errors = errors + 1;
    tally_and_finish;
  end

  initial begin
    errors = 0;
    n_tests = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    ee.lat = 2;
    ee.mem[0] = ~SIG;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults;
    t_load_fast;
    t_load_slow;
    t_reset_mid;
    t_bad_after_good;
    t_unmapped;
    tally_and_finish;
  end
endmodule
